//--- src/csb_pkg.sv
// Behaviour
// - Stack pointer resets to 07H on every reset; first push lands at 08H.
// - Push increments the stack pointer first, then writes at the new address.
// - Watchdog, brown-out, flash trigger, chip control, flash base writes need timed access.
// - Brown-out enable, level and reset-enable load from config on power-on only.
// - With configured brown-out enable 1, power-on reset sets the brown-out level bit.
// - Power-on loads watchdog enable and boot select as inverted config bits.
// - Watchdog enable and boot select reload from config on every reset; brown-out config bits survive all but power-on reset.
// - Watchdog control: power-on clears bits 6:0; other resets clear bit 6 and keep bits 5:0; watchdog reset sets its flag.
// - Brown-out flag is 1 after brown-out reset, 0 after other non-power-on resets.
// - Power control resets to 10H on power-on; others clear all but power-on flag.
// - Chip control clears on every reset except boot select bit 1 from config.
// - Data-flash base loads config on power-on and keeps its value otherwise.
// - Each bit of a bit-addressable register has its own bit address.
// - Second operand register holds multiply/divide operand and result, else plain byte.
// - Key register resets to FFH; other core registers reset to zero except stack pointer.
// - Two bank-select bits of program status pick one of four working banks.
package csb_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_SP     = 8'h81;
  localparam logic [7:0] ADDR_DPL    = 8'h82;
  localparam logic [7:0] ADDR_DPH    = 8'h83;
  localparam logic [7:0] ADDR_POWER_CONTROL   = 8'h87;
  localparam logic [7:0] ADDR_FBASE  = 8'h9C;
  localparam logic [7:0] ADDR_CHIP   = 8'h9F;
  localparam logic [7:0] ADDR_BROWN  = 8'hA3;
  localparam logic [7:0] ADDR_FTRIG  = 8'hA4;
  localparam logic [7:0] ADDR_WDTX   = 8'hAB;
  localparam logic [7:0] ADDR_KEY    = 8'hC7;
  localparam logic [7:0] ADDR_PSW    = 8'hD0;
  localparam logic [7:0] ADDR_WDT    = 8'hD8;
  localparam logic [7:0] ADDR_ACC    = 8'hE0;
  localparam logic [7:0] ADDR_B      = 8'hF0;
  // ****************************************
  // Reset values, masks and field positions
  // ****************************************
  localparam logic [7:0] RST_SP      = 8'h07;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_KEY     = 8'hFF;
  localparam logic [7:0] RST_POWER_CONTROL    = 8'h10;
  localparam logic [7:0] POWER_CONTROL_KEEP   = 8'h10;
  localparam logic [7:0] WDT_KEEP    = 8'h3F;
  localparam logic [7:0] BROWN_KEEP  = 8'hD0;
  localparam logic [7:0] POWER_CONTROL_WMASK  = 8'hDF;
  localparam logic [7:0] CHIP_WMASK  = 8'hE3;
  localparam logic [7:0] BROWN_WMASK = 8'hD8;
  localparam logic [7:0] ONE_WMASK   = 8'h01;
  localparam int WDT_EN_BIT = 7;
  localparam int WDT_RF_BIT = 3;
  localparam int BOD_EN_BIT = 7;
  localparam int BOV_BIT    = 6;
  localparam int BROWNOUT_RESET_ENABLE_BIT  = 4;
  localparam int BOF_BIT    = 3;
  localparam int BOS_BIT    = 0;
  localparam int BOOT_BIT   = 1;
  localparam int BANK_LO    = 3;
  // ****************************************
  // Timed access
  // ****************************************
  localparam logic [7:0] KEY_FIRST   = 8'hAA;
  localparam logic [7:0] KEY_SECOND  = 8'h55;
  localparam logic [2:0] KEY_WINDOW  = 3'h4;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {CSB_POR, CSB_WDT, CSB_BOD, CSB_OTHER} csb_cause_e;
  typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} csb_key_e;
  typedef struct packed {
    logic       config_watchdog_enable;
    logic       config_boot_select;
    logic       brownout_enable;
    logic       brownout_level;
    logic       brownout_reset_enable;
    logic [7:0] config_flash_base;
  } csb_cfg_s;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       bit_op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_val;
  } csb_req_s;
  typedef struct packed {
    logic       watchdog_enable;
    logic       boot_select;
    logic [1:0] bank_select;
    logic [7:0] flash_base;
    logic       flash_go;
  } csb_ctl_s;
endpackage : csb_pkg

//--- src/csb_sfr_bank.sv
module csb_sfr_bank (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire csb_pkg::csb_cause_e rst_cause,
  input  wire csb_pkg::csb_cfg_s   cfg,
  input  wire logic                brownout_status,
  // Direct register access
  input  wire csb_pkg::csb_req_s   req,
  output logic [7:0]               rdata,
  output logic                     rbit,
  // Stack
  input  wire logic                stack_push,
  input  wire logic                stack_pop,
  output logic [7:0]               stack_addr,
  output logic                     stack_wr,
  output logic                     stack_rd,
  // Core updates
  input  wire logic                alu_load,
  input  wire logic [7:0]          alu_acc,
  input  wire logic [7:0]          alu_b,
  input  wire logic                psw_load,
  input  wire logic [7:0]          psw_value,
  // Core view
  output logic [7:0]               acc_q,
  output logic [7:0]               b_q,
  output logic [7:0]               psw_q,
  output logic [7:0]               sp_q,
  output logic [15:0]              dptr_q,
  output csb_pkg::csb_ctl_s        ctl
);
  import csb_pkg::*;

  logic [7:0] sp_ff, dpl_ff, dph_ff, power_control_ff, fbase_ff, chip_ff, brown_ff;
  logic [7:0] wdtx_ff, key_ff, psw_ff, wdt_ff, acc_ff, b_ff;
  logic [7:0] nxt_sp, nxt_dpl, nxt_dph, nxt_power_control, nxt_fbase, nxt_chip, nxt_brown;
  logic [7:0] nxt_wdtx, nxt_key, nxt_psw, nxt_wdt, nxt_acc, nxt_b;
  logic [7:0] rdata_ff, nxt_rdata, stack_addr_ff, nxt_stack_addr;
  logic       rbit_ff, nxt_rbit, stack_wr_ff, nxt_stack_wr;
  logic       stack_rd_ff, nxt_stack_rd, go_ff, nxt_go;
  csb_key_e   key_st_ff, nxt_key_st;
  logic [2:0] key_cnt_ff, nxt_key_cnt;
  logic [7:0] waddr, wcur, wval, rsel;
  logic       wr_ok, prot, por;

  // ****************************************
  // Read selection
  // ****************************************
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_SP) v = sp_ff;
    else if (a == ADDR_DPL) v = dpl_ff;
    else if (a == ADDR_DPH) v = dph_ff;
    else if (a == ADDR_POWER_CONTROL) v = power_control_ff;
    else if (a == ADDR_FBASE) v = fbase_ff;
    else if (a == ADDR_CHIP) v = chip_ff;
    else if (a == ADDR_BROWN) v = {brown_ff[7:1], brownout_status};
    else if (a == ADDR_WDTX) v = wdtx_ff;
    else if (a == ADDR_KEY) v = key_ff;
    else if (a == ADDR_PSW) v = psw_ff;
    else if (a == ADDR_WDT) v = wdt_ff;
    else if (a == ADDR_ACC) v = acc_ff;
    else if (a == ADDR_B) v = b_ff;
    return v;
  endfunction : read_byte

  // Bit addresses map to byte {a[7:3],000}, bit a[2:0]
  always_comb begin
    waddr = req.bit_op ? {req.addr[7:3], 3'b000} : req.addr;
    wcur  = read_byte(waddr);
    wval  = req.wdata;
    if (req.bit_op) begin
      wval = wcur;
      wval[req.addr[2:0]] = req.bit_val;
    end
    rsel  = read_byte(waddr);
    prot  = (waddr == ADDR_WDT) || (waddr == ADDR_WDTX) || (waddr == ADDR_BROWN) ||
            (waddr == ADDR_FTRIG) || (waddr == ADDR_CHIP) || (waddr == ADDR_FBASE);
    wr_ok = req.wr && (!prot || key_st_ff == KEY_OPEN);
    por   = (rst_cause == CSB_POR);
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    nxt_sp = sp_ff;       nxt_dpl = dpl_ff;     nxt_dph = dph_ff;
    nxt_power_control = power_control_ff;   nxt_fbase = fbase_ff; nxt_chip = chip_ff;
    nxt_brown = brown_ff; nxt_wdtx = wdtx_ff;   nxt_key = key_ff;
    nxt_psw = psw_ff;     nxt_wdt = wdt_ff;     nxt_acc = acc_ff;
    nxt_b = b_ff;         nxt_rdata = rdata_ff; nxt_rbit = rbit_ff;
    nxt_stack_addr = stack_addr_ff;
    nxt_stack_wr = 1'b0;  nxt_stack_rd = 1'b0;  nxt_go = 1'b0;
    nxt_key_st = key_st_ff;
    nxt_key_cnt = key_cnt_ff;
    if (!rst_n) begin
      nxt_sp = RST_SP;
      nxt_dpl = RST_ZERO; nxt_dph = RST_ZERO; nxt_psw = RST_ZERO;
      nxt_acc = RST_ZERO; nxt_b = RST_ZERO; nxt_key = RST_KEY;
      nxt_wdtx = RST_ZERO;
      nxt_key_st = KEY_LOCKED;
      nxt_key_cnt = 3'h0;
      nxt_stack_addr = RST_ZERO;
      nxt_rdata = RST_ZERO;
      nxt_rbit = 1'b0;
      nxt_chip = RST_ZERO;
      nxt_chip[BOOT_BIT] = ~cfg.config_boot_select;
      if (por) begin
        nxt_power_control = RST_POWER_CONTROL;
        nxt_fbase = cfg.config_flash_base;
        nxt_wdt = RST_ZERO;
        nxt_brown = RST_ZERO;
        nxt_brown[BOD_EN_BIT] = cfg.brownout_enable;
        nxt_brown[BOV_BIT] = cfg.brownout_enable | cfg.brownout_level;
        nxt_brown[BROWNOUT_RESET_ENABLE_BIT] = cfg.brownout_reset_enable;
        nxt_brown[BOF_BIT] = 1'b1;
      end else begin
        nxt_power_control = power_control_ff & POWER_CONTROL_KEEP;
        nxt_wdt = wdt_ff & WDT_KEEP;
        if (rst_cause == CSB_WDT) nxt_wdt[WDT_RF_BIT] = 1'b1;
        nxt_brown = brown_ff & BROWN_KEEP;
        nxt_brown[BOF_BIT] = (rst_cause == CSB_BOD);
      end
      nxt_wdt[WDT_EN_BIT] = ~cfg.config_watchdog_enable;
    end else begin
      if (req.rd) begin
        nxt_rdata = rsel;
        nxt_rbit = rsel[req.addr[2:0]];
      end
      // Timed-access key sequence
      case (key_st_ff)
        KEY_HALF, KEY_OPEN: begin
          nxt_key_cnt = key_cnt_ff - 3'h1;
          if (key_cnt_ff == 3'h1) nxt_key_st = KEY_LOCKED;
        end
        default: nxt_key_cnt = 3'h0;
      endcase
      if (req.wr && waddr == ADDR_KEY) begin
        nxt_key = wval;
        nxt_key_st = KEY_LOCKED;
        nxt_key_cnt = 3'h0;
        if (wval == KEY_FIRST) begin
          nxt_key_st = KEY_HALF;
          nxt_key_cnt = KEY_WINDOW;
        end else if (wval == KEY_SECOND && key_st_ff == KEY_HALF) begin
          nxt_key_st = KEY_OPEN;
          nxt_key_cnt = KEY_WINDOW;
        end
      end
      // A protected write spends the unlock, accepted or not
      if (req.wr && prot) begin
        nxt_key_st = KEY_LOCKED;
        nxt_key_cnt = 3'h0;
      end
      if (wr_ok) begin
        if (waddr == ADDR_SP) nxt_sp = wval;
        else if (waddr == ADDR_DPL) nxt_dpl = wval;
        else if (waddr == ADDR_DPH) nxt_dph = wval;
        else if (waddr == ADDR_POWER_CONTROL) nxt_power_control = wval & POWER_CONTROL_WMASK;
        else if (waddr == ADDR_FBASE) nxt_fbase = wval;
        else if (waddr == ADDR_CHIP) nxt_chip = wval & CHIP_WMASK;
        else if (waddr == ADDR_BROWN) nxt_brown = wval & BROWN_WMASK;
        else if (waddr == ADDR_FTRIG) nxt_go = wval[0];
        else if (waddr == ADDR_WDTX) nxt_wdtx = wval & ONE_WMASK;
        else if (waddr == ADDR_PSW) nxt_psw = wval;
        else if (waddr == ADDR_WDT) nxt_wdt = wval;
        else if (waddr == ADDR_ACC) nxt_acc = wval;
        else if (waddr == ADDR_B) nxt_b = wval;
      end
      if (psw_load) nxt_psw = psw_value;
      if (alu_load) begin
        nxt_acc = alu_acc;
        nxt_b = alu_b;
      end
      // Stack moves win over a direct write to the pointer
      if (stack_push) begin
        nxt_sp = sp_ff + 8'h01;
        nxt_stack_addr = sp_ff + 8'h01;
        nxt_stack_wr = 1'b1;
      end else if (stack_pop) begin
        nxt_stack_addr = sp_ff;
        nxt_stack_rd = 1'b1;
        nxt_sp = sp_ff - 8'h01;
      end
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clk) begin
    sp_ff <= nxt_sp;       dpl_ff <= nxt_dpl;     dph_ff <= nxt_dph;
    power_control_ff <= nxt_power_control;   fbase_ff <= nxt_fbase; chip_ff <= nxt_chip;
    brown_ff <= nxt_brown; wdtx_ff <= nxt_wdtx;   key_ff <= nxt_key;
    psw_ff <= nxt_psw;     wdt_ff <= nxt_wdt;     acc_ff <= nxt_acc;
    b_ff <= nxt_b;         rdata_ff <= nxt_rdata; rbit_ff <= nxt_rbit;
    stack_addr_ff <= nxt_stack_addr;
    stack_wr_ff <= nxt_stack_wr;
    stack_rd_ff <= nxt_stack_rd;
    go_ff <= nxt_go;
    key_st_ff <= nxt_key_st;
    key_cnt_ff <= nxt_key_cnt;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata = rdata_ff;
  assign rbit = rbit_ff;
  assign stack_addr = stack_addr_ff;
  assign stack_wr = stack_wr_ff;
  assign stack_rd = stack_rd_ff;
  assign acc_q = acc_ff;
  assign b_q = b_ff;
  assign psw_q = psw_ff;
  assign sp_q = sp_ff;
  assign dptr_q = {dph_ff, dpl_ff};
  assign ctl.watchdog_enable = wdt_ff[WDT_EN_BIT];
  assign ctl.boot_select = chip_ff[BOOT_BIT];
  assign ctl.bank_select = psw_ff[BANK_LO+1:BANK_LO];
  assign ctl.flash_base = fbase_ff;
  assign ctl.flash_go = go_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_key_aa;
    req.wr && !req.bit_op && req.addr == ADDR_KEY && req.wdata == KEY_FIRST;
  endsequence
  sequence s_key_55;
    req.wr && !req.bit_op && req.addr == ADDR_KEY && req.wdata == KEY_SECOND;
  endsequence
  sequence s_prot_wr;
    req.wr && !req.bit_op && req.addr == ADDR_WDTX;
  endsequence

  chk_sp_reset: assert property ($rose(rst_n) |-> sp_ff == RST_SP)
    else $error("stack pointer not 07H after reset");
  chk_push_order: assert property (stack_push |=> stack_wr && stack_addr == sp_ff
    && sp_ff == $past(sp_ff) + 8'h01)
    else $error("push did not pre-increment");
  chk_key_open: assert property (s_key_aa ##1 s_key_55 ##1 s_prot_wr
    |=> wdtx_ff == ($past(req.wdata) & ONE_WMASK))
    else $error("unlocked protected write lost");
  chk_key_block: assert property ((key_st_ff == KEY_LOCKED) and s_prot_wr
    |=> $stable(wdtx_ff))
    else $error("locked protected write took effect");
  chk_bod_keep: assert property ($rose(rst_n) && $past(rst_cause) != CSB_POR
    |-> (brown_ff & BROWN_KEEP) == ($past(brown_ff) & BROWN_KEEP))
    else $error("brown-out settings changed on warm reset");
  chk_bov_set: assert property ($rose(rst_n) && $past(rst_cause) == CSB_POR
    && $past(cfg.brownout_enable) |-> brown_ff[BOV_BIT])
    else $error("brown-out level not set");
  chk_wdt_por: assert property ($rose(rst_n) && $past(rst_cause) == CSB_POR
    |-> wdt_ff == {~$past(cfg.config_watchdog_enable), 7'h00}
    && ctl.boot_select == ~$past(cfg.config_boot_select))
    else $error("power-on watchdog or boot select wrong");
  chk_wdt_flag: assert property ($rose(rst_n) && $past(rst_cause) == CSB_WDT
    |-> wdt_ff[WDT_RF_BIT] && wdt_ff[2:0] == $past(wdt_ff[2:0]))
    else $error("watchdog reset flag wrong");
  chk_bof_flag: assert property ($rose(rst_n) && $past(rst_cause) != CSB_POR
    |-> brown_ff[BOF_BIT] == ($past(rst_cause) == CSB_BOD))
    else $error("brown-out flag wrong");
  chk_power_control_warm: assert property ($rose(rst_n) && $past(rst_cause) != CSB_POR
    |-> power_control_ff == ($past(power_control_ff) & POWER_CONTROL_KEEP))
    else $error("power control warm reset wrong");
  chk_chip_reset: assert property ($rose(rst_n) |-> (chip_ff & 8'hFD) == RST_ZERO)
    else $error("chip control not cleared");
  chk_fbase_keep: assert property ($rose(rst_n) && $past(rst_cause) != CSB_POR
    |-> fbase_ff == $past(fbase_ff))
    else $error("flash base changed on warm reset");
  chk_bit_read: assert property (req.rd && req.bit_op && req.addr == 8'hE7
    |=> rbit == $past(acc_ff[7]))
    else $error("bit read wrong");
  chk_alu_load: assert property (alu_load && !stack_push |=> b_q == $past(alu_b)
    && acc_q == $past(alu_acc))
    else $error("multiply/divide result not held");
  chk_key_reset: assert property ($rose(rst_n) |-> key_ff == RST_KEY
    && acc_ff == RST_ZERO && psw_ff == RST_ZERO && dptr_q == 16'h0000)
    else $error("core reset values wrong");
  chk_bank_bit: assert property (req.wr && req.bit_op && req.addr == 8'hD3 && !psw_load
    |=> ctl.bank_select[0] == $past(req.bit_val))
    else $error("bank select bit write lost");
  chk_pop_order: assert property (stack_pop && !stack_push |=> stack_rd
    && stack_addr == $past(sp_ff) && sp_ff == $past(sp_ff) - 8'h01)
    else $error("pop did not read before decrement");
  chk_key_expire: assert property (s_key_55 ##1 (!req.wr) [*4] ##1 s_prot_wr
    |=> $stable(wdtx_ff))
    else $error("protected write accepted after window closed");
  chk_trig_lock: assert property (key_st_ff == KEY_LOCKED && req.wr && !req.bit_op
    && req.addr == ADDR_FTRIG |=> !ctl.flash_go)
    else $error("locked flash trigger fired");
  chk_power_control_por: assert property ($rose(rst_n) && $past(rst_cause) == CSB_POR
    |-> power_control_ff == RST_POWER_CONTROL)
    else $error("power control power-on value wrong");
  chk_fbase_por: assert property ($rose(rst_n) && $past(rst_cause) == CSB_POR
    |-> fbase_ff == $past(cfg.config_flash_base))
    else $error("flash base not loaded from config");
endmodule : csb_sfr_bank

//--- dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import csb_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic       clk;
  logic       rst_n;
  csb_cause_e rst_cause;
  csb_cfg_s   cfg;
  logic       brownout_status;
  csb_req_s   req;
  logic [7:0] rdata;
  logic       rbit;
  logic       stack_push;
  logic       stack_pop;
  logic [7:0] stack_addr;
  logic       stack_wr;
  logic       stack_rd;
  logic       alu_load;
  logic [7:0] alu_acc;
  logic [7:0] alu_b;
  logic       psw_load;
  logic [7:0] psw_value;
  logic [7:0] acc_q;
  logic [7:0] b_q;
  logic [7:0] psw_q;
  logic [7:0] sp_q;
  logic [15:0] dptr_q;
  csb_ctl_s   ctl;
  int         miscompares;
  int         n_tests;

  csb_sfr_bank DUT (.clk(clk), .rst_n(rst_n), .rst_cause(rst_cause), .cfg(cfg),
    .brownout_status(brownout_status), .req(req), .rdata(rdata), .rbit(rbit),
    .stack_push(stack_push), .stack_pop(stack_pop), .stack_addr(stack_addr),
    .stack_wr(stack_wr), .stack_rd(stack_rd), .alu_load(alu_load), .alu_acc(alu_acc),
    .alu_b(alu_b), .psw_load(psw_load), .psw_value(psw_value), .acc_q(acc_q),
    .b_q(b_q), .psw_q(psw_q), .sp_q(sp_q), .dptr_q(dptr_q), .ctl(ctl));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic tick();
    @(posedge clk);
    #2;
  endtask : tick

  task automatic cyc(input logic w, input logic r, input logic b, input logic [7:0] a,
                     input logic [7:0] d, input logic bv);
    req = '{wr: w, rd: r, bit_op: b, addr: a, wdata: d, bit_val: bv};
    tick();
    req = '0;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, 1'b0, a, d, 1'b0);
    tick();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cyc(1'b0, 1'b1, 1'b0, a, 8'h00, 1'b0);
    chk({8'h00, rdata}, {8'h00, exp});
    tick();
  endtask : rd

  task automatic unlock();
    wr(ADDR_KEY, KEY_FIRST);
    wr(ADDR_KEY, KEY_SECOND);
  endtask : unlock

  task automatic do_reset(input csb_cause_e c);
    rst_n = 1'b0;
    rst_cause = c;
    tick();
    rst_n = 1'b1;
    tick();
  endtask : do_reset
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_por_values();
    rd(ADDR_SP, 8'h07);
    rd(ADDR_KEY, 8'hFF);
    rd(ADDR_ACC, 8'h00);
    rd(ADDR_B, 8'h00);
    rd(ADDR_PSW, 8'h00);
    rd(ADDR_DPL, 8'h00);
    rd(ADDR_DPH, 8'h00);
    rd(ADDR_POWER_CONTROL, 8'h10);
    rd(ADDR_FBASE, 8'h3C);
    rd(ADDR_WDT, 8'h80);
    rd(ADDR_BROWN, 8'hD8);
    rd(ADDR_CHIP, 8'h02);
    chk({15'h0, ctl.watchdog_enable}, 16'h0001);
    chk({15'h0, ctl.boot_select}, 16'h0001);
    rd(8'h84, 8'h00);
  endtask : t_por_values

  task automatic t_stack();
    stack_push = 1'b1;
    tick();
    stack_push = 1'b0;
    chk({sp_q, stack_addr}, 16'h0808);
    chk({15'h0, stack_wr}, 16'h0001);
    tick();
    chk({15'h0, stack_wr}, 16'h0000);
    stack_pop = 1'b1;
    tick();
    stack_pop = 1'b0;
    chk({sp_q, stack_addr}, 16'h0708);
    chk({15'h0, stack_rd}, 16'h0001);
    tick();
  endtask : t_stack

  task automatic t_timed_access();
    wr(ADDR_WDTX, 8'h01);
    rd(ADDR_WDTX, 8'h00);
    unlock();
    wr(ADDR_WDTX, 8'h01);
    rd(ADDR_WDTX, 8'h01);
    wr(ADDR_WDTX, 8'h00);
    rd(ADDR_WDTX, 8'h01);
    wr(ADDR_FBASE, 8'h5A);
    rd(ADDR_FBASE, 8'h3C);
    unlock();
    wr(ADDR_FBASE, 8'h5A);
    chk({8'h00, ctl.flash_base}, 16'h005A);
    unlock();
    wr(ADDR_WDT, 8'h85);
    rd(ADDR_WDT, 8'h85);
    wr(ADDR_POWER_CONTROL, 8'h0F);
    rd(ADDR_POWER_CONTROL, 8'h0F);
  endtask : t_timed_access

  task automatic t_key_timing();
    req = '{1'b1, 1'b0, 1'b0, ADDR_KEY, KEY_FIRST, 1'b0};
    tick();
    req.wdata = KEY_SECOND;
    tick();
    req = '{1'b1, 1'b0, 1'b0, ADDR_WDTX, 8'h00, 1'b0};
    tick();
    req = '0;
    tick();
    rd(ADDR_WDTX, 8'h00);
    unlock();
    repeat (3) tick();
    wr(ADDR_WDTX, 8'h01);
    rd(ADDR_WDTX, 8'h00);
    cyc(1'b1, 1'b0, 1'b0, ADDR_FTRIG, 8'h01, 1'b0);
    chk({15'h0, ctl.flash_go}, 16'h0000);
    tick();
    unlock();
    cyc(1'b1, 1'b0, 1'b0, ADDR_FTRIG, 8'h01, 1'b0);
    chk({15'h0, ctl.flash_go}, 16'h0001);
    tick();
    chk({15'h0, ctl.flash_go}, 16'h0000);
  endtask : t_key_timing

  task automatic t_bits_and_core();
    cyc(1'b1, 1'b0, 1'b1, 8'hD3, 8'h00, 1'b1);
    tick();
    chk({8'h00, psw_q}, 16'h0008);
    chk({14'h0, ctl.bank_select}, 16'h0001);
    cyc(1'b1, 1'b0, 1'b1, 8'hE7, 8'h00, 1'b1);
    tick();
    chk({8'h00, acc_q}, 16'h0080);
    cyc(1'b0, 1'b1, 1'b1, 8'hE7, 8'h00, 1'b0);
    chk({15'h0, rbit}, 16'h0001);
    tick();
    alu_load = 1'b1;
    alu_acc = 8'h12;
    alu_b = 8'h34;
    tick();
    alu_load = 1'b0;
    rd(ADDR_B, 8'h34);
    wr(ADDR_B, 8'hC3);
    chk({8'h00, b_q}, 16'h00C3);
    psw_load = 1'b1;
    psw_value = 8'h10;
    tick();
    psw_load = 1'b0;
    chk({14'h0, ctl.bank_select}, 16'h0002);
    wr(ADDR_DPH, 8'hAB);
    wr(ADDR_DPL, 8'hCD);
    chk(dptr_q, 16'hABCD);
    brownout_status = 1'b1;
    rd(ADDR_BROWN, 8'hD9);
    brownout_status = 1'b0;
  endtask : t_bits_and_core

  task automatic t_warm_resets();
    cfg.brownout_enable = 1'b0;
    cfg.brownout_reset_enable = 1'b0;
    cfg.config_flash_base = 8'h77;
    do_reset(CSB_WDT);
    rd(ADDR_SP, 8'h07);
    rd(ADDR_WDT, 8'h8D);
    rd(ADDR_POWER_CONTROL, 8'h00);
    rd(ADDR_FBASE, 8'h5A);
    rd(ADDR_BROWN, 8'hD0);
    rd(ADDR_WDTX, 8'h00);
    rd(ADDR_CHIP, 8'h02);
    do_reset(CSB_BOD);
    rd(ADDR_BROWN, 8'hD8);
    rd(ADDR_WDT, 8'h8D);
    do_reset(CSB_OTHER);
    rd(ADDR_BROWN, 8'hD0);
    do_reset(CSB_POR);
    rd(ADDR_BROWN, 8'h08);
    rd(ADDR_FBASE, 8'h77);
    rd(ADDR_POWER_CONTROL, 8'h10);
  endtask : t_warm_resets
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    miscompares = 0;
    n_tests = 0;
    rst_n = 1'b0;
    rst_cause = CSB_POR;
    cfg = '{config_watchdog_enable: 1'b0, config_boot_select: 1'b0, brownout_enable: 1'b1,
            brownout_level: 1'b0, brownout_reset_enable: 1'b1, config_flash_base: 8'h3C};
    brownout_status = 1'b0;
    req = '0;
    stack_push = 1'b0;
    stack_pop = 1'b0;
    alu_load = 1'b0;
    alu_acc = 8'h00;
    alu_b = 8'h00;
    psw_load = 1'b0;
    psw_value = 8'h00;
    repeat (20) @(posedge clk);
    #2;
    rst_n = 1'b1;
    tick();
    t_por_values();
    t_stack();
    t_timed_access();
    t_key_timing();
    t_bits_and_core();
    t_warm_resets();
    print_verdict();
  end

  initial begin
    #(25 * 3000);
    miscompares++;
    print_verdict();
  end
endmodule : testbench
